// ==== logic/fsvr_top.v ====
// Fault status register two, voltage-ID register and interrupt mask
// Assumes AXI4-Lite master on clock; fault levels from same-clock logic
`timescale 1ns/1ns
`default_nettype none
`include "fsvr_defs.vh"

module fsvr_top #(
  parameter TIMER_UNIT_CYC = `FSVR_TIMER_UNIT_CYC
) (
  input wire clock,
  input wire rst_n,
  input wire [11:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [11:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire supply_limit_fault,
  input wire overtemp_exceeded,
  input wire overtemp_below_hyst,
  input wire [3:0] fan_underspeed,
  input wire [2:0] fan_drive_on,
  input wire [1:0] diode_fault,
  input wire [1:0] fan_four_mode,
  input wire [7:0] thermal_limit,
  input wire thermal_alarm_signal,
  input wire [5:0] voltage_id_pins,
  output reg fan_four_gpio_out,
  output wire fan_four_gpio_oe_n,
  output reg id_threshold_select,
  output reg shared_pin_select,
  output wire out_of_limit_summary,
  output wire irq
);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function [7:0] reg_index;
    input [11:0] addr;
    begin
      reg_index = addr[9:2];
    end
  endfunction

  function mapped;
    input [11:0] addr;
    begin
      mapped = (addr[11:10] == 2'h0) &&
        ((addr[9:2] == `FSVR_IDX_STATUS) ||
         (addr[9:2] == `FSVR_IDX_VID) ||
         (addr[9:2] == `FSVR_IDX_MASK));
    end
  endfunction

  function fan_fault;
    input underspeed;
    input drive_on;
    begin
      // A fan with its drive off is stopped on purpose
      fan_fault = underspeed & drive_on;
    end
  endfunction

  function is_reg;
    input [11:0] addr;
    input [7:0] idx;
    begin
      is_reg = mapped(addr) && (reg_index(addr) == idx);
    end
  endfunction

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg aw_held;
  reg w_held;
  reg [11:0] aw_addr;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg [7:0] irq_mask;
  reg alarm_a;
  reg alarm_b;
  reg [31:0] unit_count;
  reg [7:0] alarm_time;
  reg timer_over;
  reg [7:0] next_set;
  reg [7:0] next_hold;
  wire [5:0] vid_now;
  wire vid_changed;
  wire [7:0] flags;
  wire [7:0] status_view;
  wire [7:0] vid_view;
  wire [7:0] int_source;
  wire do_write;
  wire do_read;
  wire status_read;
  wire gpio_mode;
  wire tach_mode;
  wire timer_mode;
  wire [7:0] wr_index;
  wire wr_lane0;

  assign gpio_mode = (fan_four_mode == `FSVR_F4_GPIO);
  assign tach_mode = (fan_four_mode == `FSVR_F4_TACH);
  assign timer_mode = (fan_four_mode == `FSVR_F4_TIMER);

  // ----------------------------------------
  // Voltage-ID watch
  // ----------------------------------------
  fsvr_vid_watch u_vid (
    .clock(clock),
    .rst_n(rst_n),
    .vid_pins(voltage_id_pins),
    .use_sixth(shared_pin_select),
    .vid_now(vid_now),
    .vid_changed(vid_changed)
  );

  // ----------------------------------------
  // Thermal alarm time accumulator
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      alarm_a <= 1'b0;
      alarm_b <= 1'b0;
    end else begin
      alarm_a <= thermal_alarm_signal;
      alarm_b <= alarm_a;
    end
  end

  // Time counts in units while the alarm is asserted; a status read restarts it
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      unit_count <= 32'h00000000;
      alarm_time <= 8'h00;
      timer_over <= 1'b0;
    end else begin
      timer_over <= timer_mode && (alarm_time > thermal_limit);
      if (!timer_mode || status_read) begin
        unit_count <= 32'h00000000;
        alarm_time <= 8'h00;
      end else if (alarm_b) begin
        if (unit_count == TIMER_UNIT_CYC - 1) begin
          unit_count <= 32'h00000000;
          if (alarm_time != 8'hFF) begin
            alarm_time <= alarm_time + 8'h01;
          end
        end else begin
          unit_count <= unit_count + 32'h00000001;
        end
      end
    end
  end

  // ----------------------------------------
  // Fault set and hold terms
  // ----------------------------------------
  always @* begin
    next_set = 8'h00;
    next_hold = 8'h00;
    if (shared_pin_select) begin
      next_set[`FSVR_BIT_SUPPLY] = vid_changed;
      next_hold[`FSVR_BIT_SUPPLY] = vid_changed;
    end else begin
      next_set[`FSVR_BIT_SUPPLY] = supply_limit_fault;
      next_hold[`FSVR_BIT_SUPPLY] = supply_limit_fault;
    end
    next_set[`FSVR_BIT_OVT] = overtemp_exceeded;
    next_hold[`FSVR_BIT_OVT] = !overtemp_below_hyst;
    next_set[`FSVR_BIT_FAN_ONE_FAULT] = fan_fault(fan_underspeed[0], fan_drive_on[0]);
    next_set[`FSVR_BIT_FAN_TWO_FAULT] = fan_fault(fan_underspeed[1], fan_drive_on[1]);
    next_set[`FSVR_BIT_FAN_THREE_FAULT] = fan_fault(fan_underspeed[2], fan_drive_on[2]);
    next_hold[`FSVR_BIT_FAN_ONE_FAULT] = next_set[`FSVR_BIT_FAN_ONE_FAULT];
    next_hold[`FSVR_BIT_FAN_TWO_FAULT] = next_set[`FSVR_BIT_FAN_TWO_FAULT];
    next_hold[`FSVR_BIT_FAN_THREE_FAULT] = next_set[`FSVR_BIT_FAN_THREE_FAULT];
    if (tach_mode) begin
      next_set[`FSVR_BIT_F4] = fan_fault(fan_underspeed[3], fan_drive_on[2]);
    end else if (timer_mode) begin
      next_set[`FSVR_BIT_F4] = timer_over;
    end else begin
      next_set[`FSVR_BIT_F4] = 1'b0;
    end
    next_hold[`FSVR_BIT_F4] = next_set[`FSVR_BIT_F4];
    next_set[`FSVR_BIT_D1] = diode_fault[0];
    next_set[`FSVR_BIT_D2] = diode_fault[1];
    next_hold[`FSVR_BIT_D1] = diode_fault[0];
    next_hold[`FSVR_BIT_D2] = diode_fault[1];
  end

  fsvr_sticky u_sticky (
    .clock(clock),
    .rst_n(rst_n),
    .set(next_set),
    .hold(next_hold),
    .read_clear(status_read),
    .flags(flags)
  );

  // ----------------------------------------
  // Register views
  // ----------------------------------------
  // In output mode bit 5 reads back the driven level
  assign status_view = gpio_mode ?
    {flags[7:6], fan_four_gpio_out, flags[4:0]} : flags;
  assign vid_view = {shared_pin_select, id_threshold_select, vid_now};
  assign out_of_limit_summary = |status_view;
  assign fan_four_gpio_oe_n = !gpio_mode;

  // ----------------------------------------
  // Interrupt
  // ----------------------------------------
  // Masked bit = 1 blocks it; output-mode bit 5 is data, not an event
  assign int_source = gpio_mode ? (flags & 8'hDF) : flags;
  assign irq = |(int_source & ~irq_mask);

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  // Address and data may arrive in either order
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_index = reg_index(aw_addr);
  assign wr_lane0 = w_strb[0];

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `FSVR_RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(aw_addr) ? `FSVR_RESP_OKAY : `FSVR_RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------
  // Writable fields
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      irq_mask <= `FSVR_RST_MASK;
      fan_four_gpio_out <= 1'b0;
      id_threshold_select <= 1'b0;
      shared_pin_select <= 1'b0;
    end else if (do_write && wr_lane0 && aw_addr[11:10] == 2'h0) begin
      if (wr_index == `FSVR_IDX_MASK) begin
        irq_mask <= w_data[7:0];
      end
      if (wr_index == `FSVR_IDX_STATUS && gpio_mode) begin
        fan_four_gpio_out <= w_data[`FSVR_BIT_F4];
      end
      if (wr_index == `FSVR_IDX_VID) begin
        id_threshold_select <= w_data[`FSVR_BIT_ID_THRESHOLD_SELECT];
        shared_pin_select <= w_data[`FSVR_BIT_PSEL];
      end
    end
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign do_read = s_axi_arvalid && s_axi_arready;
  assign status_read = do_read && is_reg(s_axi_araddr, `FSVR_IDX_STATUS);

  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `FSVR_RESP_OKAY;
    end else if (do_read) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `FSVR_RESP_OKAY;
      s_axi_rdata <= 32'h00000000;
      if (!mapped(s_axi_araddr)) begin
        s_axi_rresp <= `FSVR_RESP_SLVERR;
      end else if (reg_index(s_axi_araddr) == `FSVR_IDX_STATUS) begin
        s_axi_rdata <= {24'h000000, status_view};
      end else if (reg_index(s_axi_araddr) == `FSVR_IDX_VID) begin
        s_axi_rdata <= {24'h000000, vid_view};
      end else begin
        s_axi_rdata <= {24'h000000, irq_mask};
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// ==== logic/fsvr_defs.vh ====
// Constants for the fault status and voltage-ID register block
// Assumes 20 MHz clock and AXI4-Lite access with 32-bit data
`ifndef FSVR_DEFS_VH
`define FSVR_DEFS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define FSVR_IDX_STATUS 8'h42
`define FSVR_IDX_VID 8'h43
`define FSVR_IDX_MASK 8'h90

// ----------------------------------------
// Reset values
// ----------------------------------------
`define FSVR_RST_STATUS 8'h00
`define FSVR_RST_VID 8'h00
`define FSVR_RST_MASK 8'h00

// ----------------------------------------
// Field positions
// ----------------------------------------
`define FSVR_BIT_SUPPLY 0
`define FSVR_BIT_OVT 1
`define FSVR_BIT_FAN_ONE_FAULT 2
`define FSVR_BIT_FAN_TWO_FAULT 3
`define FSVR_BIT_FAN_THREE_FAULT 4
`define FSVR_BIT_F4 5
`define FSVR_BIT_D1 6
`define FSVR_BIT_D2 7
`define FSVR_BIT_ID_THRESHOLD_SELECT 6
`define FSVR_BIT_PSEL 7

// ----------------------------------------
// Bit 5 pin functions
// ----------------------------------------
`define FSVR_F4_TACH 2'h0
`define FSVR_F4_GPIO 2'h1
`define FSVR_F4_TIMER 2'h2

// ----------------------------------------
// Bus responses
// ----------------------------------------
`define FSVR_RESP_OKAY 2'h0
`define FSVR_RESP_SLVERR 2'h2

// ----------------------------------------
// Timing
// ----------------------------------------
`define FSVR_CLK_PERIOD_NS 50
`define FSVR_VID_WINDOW_NS 11000
`define FSVR_VID_WINDOW_CYC (`FSVR_VID_WINDOW_NS / `FSVR_CLK_PERIOD_NS)
`define FSVR_TIMER_UNIT_NS 1000000
`define FSVR_TIMER_UNIT_CYC (`FSVR_TIMER_UNIT_NS / `FSVR_CLK_PERIOD_NS)

`endif

// ==== logic/fsvr_vid_watch.v ====
// Voltage-ID pin synchroniser and change detector
// Assumes asynchronous pins and the block clock
`timescale 1ns/1ns
`default_nettype none
`include "fsvr_defs.vh"

module fsvr_vid_watch (
  input wire clock,
  input wire rst_n,
  input wire [5:0] vid_pins,
  input wire use_sixth,
  output reg [5:0] vid_now,
  output reg vid_changed
);

  localparam integer WINDOW_CYC = `FSVR_VID_WINDOW_CYC;
  localparam [7:0] WINDOW = WINDOW_CYC[7:0];

  reg [5:0] sync_a;
  reg [5:0] sync_b;
  reg [5:0] snap;
  reg [7:0] timer;
  wire [5:0] masked;

  assign masked = {sync_b[5] & use_sixth, sync_b[4:0]};

  // ----------------------------------------
  // Two-stage synchroniser
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sync_a <= 6'h00;
      sync_b <= 6'h00;
    end else begin
      sync_a <= vid_pins;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------
  // Compare with code seen one window earlier
  // ----------------------------------------
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      snap <= 6'h00;
      timer <= 8'h00;
      vid_now <= 6'h00;
      vid_changed <= 1'b0;
    end else begin
      vid_now <= masked;
      vid_changed <= 1'b0;
      if (timer == WINDOW - 8'h01) begin
        timer <= 8'h00;
        snap <= masked;
        vid_changed <= (masked != snap);
      end else begin
        timer <= timer + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// ==== logic/fsvr_sticky.v ====
// Eight sticky fault flags, cleared by a status read once subsided
// Assumes set and hold levels from logic on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "fsvr_defs.vh"

module fsvr_sticky (
  input wire clock,
  input wire rst_n,
  input wire [7:0] set,
  input wire [7:0] hold,
  input wire read_clear,
  output reg [7:0] flags
);

  // Set wins over a clear in the same cycle
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      flags <= `FSVR_RST_STATUS;
    end else begin
      flags <= set | (flags & ~({8{read_clear}} & ~hold));
    end
  end

endmodule
`default_nettype wire

// ==== verif/fsvr_chk_sva.sv ====
// Checker for fsvr_top: bus handshakes, sticky flags, summary and pin enable
// Assumes binding into fsvr_top with its ports visible by name
`timescale 1ns/1ns
`default_nettype none
`include "fsvr_defs.vh"
module fsvr_chk #(
  parameter TIMER_UNIT_CYC = 4
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic supply_limit_fault,
  input wire logic shared_pin_select,
  input wire logic [1:0] diode_fault,
  input wire logic [1:0] fan_four_mode,
  input wire logic fan_four_gpio_oe_n,
  input wire logic out_of_limit_summary,
  input wire logic irq
);
  // ----
  // Properties
  // ----
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  sequence aw_w_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  write_resp_a: assert property (aw_w_taken |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  read_resp_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read response missing");
  b_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  r_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready && s_axi_rdata[31:8] == 24'h0)
    else $error("read response malformed");
  supply_set_a: assert property (supply_limit_fault && !shared_pin_select
    |=> out_of_limit_summary)
    else $error("supply fault not flagged");
  diode_set_a: assert property (|diode_fault |=> out_of_limit_summary)
    else $error("diode fault not flagged");
  irq_summary_a: assert property (irq |-> out_of_limit_summary)
    else $error("interrupt without summary");
  pin_enable_a: assert property (fan_four_gpio_oe_n == (fan_four_mode != `FSVR_F4_GPIO))
    else $error("output enable wrong for mode");
  sticky_hold_a: assert property ($fell(out_of_limit_summary) && $stable(fan_four_mode)
    && fan_four_mode != `FSVR_F4_GPIO |-> $past(s_axi_arvalid && s_axi_arready))
    else $error("flag dropped without a read");
endmodule
bind fsvr_top fsvr_chk #(.TIMER_UNIT_CYC(TIMER_UNIT_CYC)) u_chk (.clock, .rst_n, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .s_axi_rdata, .supply_limit_fault, .shared_pin_select, .diode_fault,
  .fan_four_mode, .fan_four_gpio_oe_n, .out_of_limit_summary, .irq);
`default_nettype wire

// ==== verif/fsvr_pins_model.sv ====
// Voltage-ID pin source standing in for the processor
// Assumes the code input is set by the bench; pins change after a clock edge
`timescale 1ns/1ns
`default_nettype none
module fsvr_pins_model (
  input wire logic clock,
  input wire logic [5:0] code,
  output logic [5:0] voltage_id_pins
);
  initial voltage_id_pins = 6'h00;
  always @(posedge clock) begin
    voltage_id_pins <= code;
  end
endmodule
`default_nettype wire

// ==== verif/fsvr_top_tb_top.sv ====
// Testbench for fsvr_top: AXI4-Lite tasks and one task per scenario
// Assumes fsvr_chk bound by its own file and fsvr_pins_model on the ID pins
`timescale 1ns/1ns
`default_nettype none
`include "fsvr_defs.vh"
module fsvr_top_tb_top;
  localparam logic [11:0] ST = 4 * `FSVR_IDX_STATUS;
  localparam logic [11:0] VD = 4 * `FSVR_IDX_VID;
  localparam logic [11:0] MK = 4 * `FSVR_IDX_MASK;
  logic clock = 0;
  logic rst_n = 0;
  logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
  logic [2:0] s_axi_awprot = 0, s_axi_arprot = 0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
  logic s_axi_rready = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic supply_limit_fault = 0, overtemp_exceeded = 0, overtemp_below_hyst = 1;
  logic [3:0] fan_underspeed = 0;
  logic [2:0] fan_drive_on = 3'h7;
  logic [1:0] diode_fault = 0, fan_four_mode = `FSVR_F4_TACH;
  logic [7:0] thermal_limit = 0;
  logic thermal_alarm_signal = 0;
  logic [5:0] code = 0;
  wire [5:0] voltage_id_pins;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire fan_four_gpio_out, fan_four_gpio_oe_n, id_threshold_select, shared_pin_select;
  wire out_of_limit_summary, irq;
  int n_fail = 0, checks = 0, cyc = 0;
  logic [31:0] d;
  logic [1:0] r;
  always #25 clock = ~clock;
  fsvr_top #(.TIMER_UNIT_CYC(4)) uut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .supply_limit_fault, .overtemp_exceeded, .overtemp_below_hyst, .fan_underspeed,
    .fan_drive_on, .diode_fault, .fan_four_mode, .thermal_limit, .thermal_alarm_signal,
    .voltage_id_pins, .fan_four_gpio_out, .fan_four_gpio_oe_n, .id_threshold_select,
    .shared_pin_select, .out_of_limit_summary, .irq);
  fsvr_pins_model pm (.clock, .code, .voltage_id_pins);
  // ----
  // Shared tasks
  // ----
  task automatic finish_test;
    if (n_fail == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    @(posedge clock);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h000000, v};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge clock);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge clock);
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask
  task automatic st(input logic [7:0] e);
    rd(ST);
    chk("status", {24'h0, e}, d);
  endtask
  task automatic ev(input int i, input logic v);
    @(posedge clock);
    case (i)
      0: supply_limit_fault <= v;
      1: overtemp_exceeded <= v;
      6, 7: diode_fault[i-6] <= v;
      default: fan_underspeed[i-2] <= v;
    endcase
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_regs;
    st(8'h00);
    rd(VD);
    chk("vid", 0, d);
    rd(MK);
    chk("mask", 0, d);
    chk("rresp", `FSVR_RESP_OKAY, r);
    rd(12'h004);
    chk("resp", `FSVR_RESP_SLVERR, r);
    chk("rdata", 0, d);
    wr(12'h004, 8'hFF);
    chk("bresp", `FSVR_RESP_SLVERR, r);
    wr(MK, 8'h00);
    chk("bresp", `FSVR_RESP_OKAY, r);
  endtask
  task automatic t_events;
    for (int i = 0; i < 8; i++) begin
      ev(i, 1'b1);
      ev(i, 1'b0);
      tick(2);
      st(8'h01 << i);
      st(8'h00);
    end
  endtask
  task automatic t_hold;
    ev(0, 1'b1);
    tick(2);
    st(8'h01);
    st(8'h01);
    ev(0, 1'b0);
    st(8'h01);
    st(8'h00);
    overtemp_below_hyst <= 1'b0;
    ev(1, 1'b1);
    ev(1, 1'b0);
    st(8'h02);
    st(8'h02);
    overtemp_below_hyst <= 1'b1;
    st(8'h02);
    st(8'h00);
    fan_drive_on <= 3'h0;
    fan_underspeed <= 4'hF;
    tick(3);
    fan_underspeed <= 4'h0;
    fan_drive_on <= 3'h7;
    st(8'h00);
  endtask
  task automatic t_irq;
    wr(MK, 8'h01);
    ev(0, 1'b1);
    ev(0, 1'b0);
    tick(2);
    chk("irq", 0, irq);
    chk("summary", 1, out_of_limit_summary);
    wr(MK, 8'h00);
    tick(1);
    chk("irq", 1, irq);
    st(8'h01);
    tick(1);
    chk("irq", 0, irq);
    chk("summary", 0, out_of_limit_summary);
  endtask
  task automatic t_gpio;
    fan_four_mode <= `FSVR_F4_GPIO;
    wr(ST, 8'h20);
    tick(1);
    chk("gpio", 1, fan_four_gpio_out);
    chk("oe_n", 0, fan_four_gpio_oe_n);
    st(8'h20);
    wr(ST, 8'h00);
    tick(1);
    chk("gpio", 0, fan_four_gpio_out);
    fan_four_mode <= `FSVR_F4_TACH;
    tick(2);
    chk("oe_n", 1, fan_four_gpio_oe_n);
  endtask
  task automatic t_timer;
    fan_four_mode <= `FSVR_F4_TIMER;
    thermal_limit <= 8'h02;
    thermal_alarm_signal <= 1'b1;
    tick(9);
    thermal_alarm_signal <= 1'b0;
    tick(12);
    chk("summary", 0, out_of_limit_summary);
    thermal_alarm_signal <= 1'b1;
    tick(8);
    thermal_alarm_signal <= 1'b0;
    tick(8);
    st(8'h20);
    fan_four_mode <= `FSVR_F4_TACH;
    tick(2);
    rd(ST);
    st(8'h00);
  endtask
  task automatic t_vid;
    code <= 6'h2A;
    tick(6);
    rd(VD);
    chk("vid", 8'h0A, d);
    wr(VD, 8'hC0);
    rd(VD);
    chk("vid", 8'hEA, d);
    chk("pins", 2'b11, {shared_pin_select, id_threshold_select});
    tick(450);
    rd(ST);
    code <= 6'h35;
    tick(500);
    chk("irq", 1, irq);
    st(8'h01);
    st(8'h00);
    wr(VD, 8'h00);
    rd(VD);
    chk("vid", 8'h15, d);
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      n_fail++;
      finish_test;
    end
  end
  initial begin
    repeat (5) @(posedge clock);
    rst_n <= 1'b1;
    t_regs;
    t_events;
    t_hold;
    t_irq;
    t_gpio;
    t_timer;
    t_vid;
    finish_test;
  end
endmodule
`default_nettype wire
